// [include/adc_seq_map.vh]
// Register offsets, field positions, codes and counts of the conversion sequencer
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// Register port byte addresses
`define REG_STATUS          8'h00
`define REG_IRQ_ENABLE      8'h04
`define REG_IRQ_CLEAR       8'h08
`define REG_CONFIG_VIEW     8'h0c
`define REG_FIFO_VIEW       8'h10

// Status, enable and clear bit positions
`define STAT_CONV_DONE      0
`define STAT_THRESHOLD      1
`define STAT_IGNORED        2
`define STAT_WIDTH          3

// Configuration register fields
`define CFG_RESET           12'h000
`define CFG_LONG_SAMPLE     10
`define CFG_DIV_HI          9
`define CFG_DIV_LO          8
`define CFG_MODE_HI         7
`define CFG_MODE_LO         6
`define CFG_THR_HI          3
`define CFG_THR_LO          2

// Conversion modes
`define MODE_SINGLE         2'b00
`define MODE_REPEAT         2'b01
`define MODE_SWEEP          2'b10
`define MODE_REPEAT_SWEEP   2'b11

// Command nibbles; 4'h0 to 4'h7 select a channel
`define CMD_POWER_DOWN      4'h8
`define CMD_READ_CONFIG     4'h9
`define CMD_WRITE_CONFIG    4'ha
`define CMD_TEST_MID        4'hb
`define CMD_TEST_ZERO       4'hc
`define CMD_TEST_FULL       4'hd
`define CMD_READ_FIFO       4'he
`define CMD_CONVERT         4'hf

// Fixed self-test result codes and out-of-range clamp codes
`define TEST_CODE_MID       12'h800
`define TEST_CODE_ZERO      12'h000
`define TEST_CODE_FULL      12'hfff
`define CODE_ALL_ONES       12'hfff
`define CODE_ALL_ZEROS      12'h000

// FIFO threshold per threshold field value
`define THR_CODE0           4'd8
`define THR_CODE1           4'd6
`define THR_CODE2           4'd4
`define THR_CODE3           4'd2

// Conversion clock divider per divider field value
`define DIV_CODE0           8'd1
`define DIV_CODE1           8'd2
`define DIV_CODE2           8'd4
`define DIV_CODE3           8'd8

// Counts in serial clock periods
`define SAMPLE_SHORT_SCLK   8'd12
`define SAMPLE_LONG_SCLK    8'd24
`define CONV_SCLK_PER_DIV   8'd14
`define NIBBLE_BITS         5'd4
`define FRAME_BITS          5'd16

`endif

// [rtl/adc_result_fifo.v]
// Eight-entry result FIFO with clear, push and pop
`timescale 1ns/1ps
module adc_result_fifo
(
    input  wire        clk,
    input  wire        reset_n,
    input  wire        clear,
    input  wire        push,
    input  wire [11:0] push_data,
    input  wire        pop,
    output wire [11:0] head_data,
    output reg  [3:0]  count
);
    reg  [11:0] entry [0:7];
    reg  [2:0]  wr_ptr;
    reg  [2:0]  rd_ptr;
    wire        do_push;
    wire        do_pop;

    assign do_push   = push && (count != 4'd8);
    assign do_pop    = pop && (count != 4'd0);
    assign head_data = entry[rd_ptr];

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_entry
            always @(posedge clk)
            begin
                if (!reset_n)
                    entry[i] <= 12'h000;
                else if (do_push && (wr_ptr == i))
                    entry[i] <= push_data;
            end
        end
    endgenerate

    always @(posedge clk)
    begin
        if (!reset_n || clear)
        begin
            wr_ptr <= 3'd0;
            rd_ptr <= 3'd0;
            count  <= 4'd0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= wr_ptr + 3'd1;
            if (do_pop)
                rd_ptr <= rd_ptr + 3'd1;
            if (do_push && !do_pop)
                count <= count + 4'd1;
            else if (do_pop && !do_push)
                count <= count - 4'd1;
        end
    end
endmodule // adc_result_fifo

// [rtl/adc_conversion_mode_sequencer.v]
// Serial command front end and conversion mode sequencer of a 12-bit converter
// Behaviour
// [RULE1] Self-test commands return 800h, 000h, FFFh
// [RULE2] Result clamps to all ones or zeros
// [RULE3] Short sampling window lasts twelve serial clocks
// [RULE4] Sweep mode stops at FIFO threshold
// [RULE5] At threshold sweep mode ignores conversion commands
// [RULE6] Repeat-sweep conversion clears FIFO, restarts sweep
// [RULE7] Repeat-sweep: reconfigure discards, or read and rerun
// [RULE8] Host reads FIFO after threshold
// [RULE9] Host selects channel before single/repeat conversions
// [RULE10] Single shot bypasses FIFO; repeat fills it
// [RULE11] Repeat: reconfigure or read; convert after select
// [RULE12] Mode 01 collects FIFO depth on channel; code stops at the FIFO threshold
// [RULE13] Sweep rerun needs no new configuration
// [RULE14] Conversion lasts fourteen times divider serial clocks
// [RULE15] Interrupt when FIFO reaches threshold
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_conversion_mode_sequencer
(
    input  wire        clk,
    input  wire        reset_n,
    input  wire        cs_n,
    input  wire        sclk,
    input  wire        sdi,
    output reg         sdo,
    output wire        sdo_oe,
    output reg  [2:0]  analog_channel,
    output wire        sample_hold,
    input  wire [11:0] raw_code,
    input  wire        above_positive_reference,
    input  wire        below_negative_reference,
    output wire        end_of_conversion,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    output wire        irq
);
    localparam ST_IDLE    = 2'd0;
    localparam ST_SAMPLE  = 2'd1;
    localparam ST_CONVERT = 2'd2;

    // Pin synchronisers: three stages, a change counts once stages two and three agree
    reg  [2:0]  cs_sync;
    reg  [2:0]  sclk_sync;
    reg  [2:0]  sdi_sync;
    reg         cs_n_f;
    reg         sclk_f;
    reg         sdi_f;
    reg         sclk_prev;
    reg         cs_n_prev;

    reg  [11:0] configuration_register;
    reg  [1:0]  state;
    reg  [7:0]  phase_cnt;
    reg  [4:0]  bit_cnt;
    reg  [14:0] shift_in;
    reg  [15:0] shift_out;
    reg  [11:0] out_word;
    reg  [2:0]  sel_channel;
    reg         channel_valid;
    reg  [2:0]  sweep_index;
    reg         threshold_hit;
    reg         in_frame;
    reg  [2:0]  status;
    reg  [2:0]  irq_enable;

    wire        sclk_rise;
    wire        sclk_fall;
    wire        frame_start;
    wire        frame_end;
    wire [1:0]  mode;
    wire [3:0]  threshold;
    wire [7:0]  divider;
    wire [7:0]  sample_len;
    wire [7:0]  conv_len;
    wire [3:0]  nibble;
    wire [15:0] command;
    wire        nibble_done;
    wire        command_done;
    wire        convert_req;
    wire        convert_ok;
    wire        restart_sweep;
    wire        conv_finish;
    wire [11:0] conv_result;
    wire        restricted;
    wire        cfg_write;
    wire        fifo_read;
    wire        fifo_push;
    wire        fifo_clear;
    wire [11:0] fifo_head;
    wire [3:0]  fifo_count;
    wire [2:0]  events;

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            cs_sync   <= 3'b111;
            sclk_sync <= 3'b000;
            sdi_sync  <= 3'b000;
        end
        else
        begin
            cs_sync   <= {cs_sync[1:0], cs_n};
            sclk_sync <= {sclk_sync[1:0], sclk};
            sdi_sync  <= {sdi_sync[1:0], sdi};
        end
    end

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            cs_n_f    <= 1'b1;
            sclk_f    <= 1'b0;
            sdi_f     <= 1'b0;
            cs_n_prev <= 1'b1;
            sclk_prev <= 1'b0;
        end
        else
        begin
            if (cs_sync[1] == cs_sync[2])
                cs_n_f <= cs_sync[2];
            if (sclk_sync[1] == sclk_sync[2])
                sclk_f <= sclk_sync[2];
            if (sdi_sync[1] == sdi_sync[2])
                sdi_f <= sdi_sync[2];
            cs_n_prev <= cs_n_f;
            sclk_prev <= sclk_f;
        end
    end

    assign sclk_rise   = sclk_f && !sclk_prev;
    assign sclk_fall   = !sclk_f && sclk_prev;
    assign frame_start = !cs_n_f && cs_n_prev;
    assign frame_end   = cs_n_f && !cs_n_prev;

    // Configuration decode
    assign mode       = configuration_register[`CFG_MODE_HI:`CFG_MODE_LO];
    assign threshold  = (configuration_register[`CFG_THR_HI:`CFG_THR_LO] == 2'd0) ? `THR_CODE0 :
                        (configuration_register[`CFG_THR_HI:`CFG_THR_LO] == 2'd1) ? `THR_CODE1 :
                        (configuration_register[`CFG_THR_HI:`CFG_THR_LO] == 2'd2) ? `THR_CODE2 :
                        `THR_CODE3;
    assign divider    = (configuration_register[`CFG_DIV_HI:`CFG_DIV_LO] == 2'd0) ? `DIV_CODE0 :
                        (configuration_register[`CFG_DIV_HI:`CFG_DIV_LO] == 2'd1) ? `DIV_CODE1 :
                        (configuration_register[`CFG_DIV_HI:`CFG_DIV_LO] == 2'd2) ? `DIV_CODE2 :
                        `DIV_CODE3;
    assign sample_len = configuration_register[`CFG_LONG_SAMPLE] ? `SAMPLE_LONG_SCLK
                                                                 : `SAMPLE_SHORT_SCLK; // RULE3
    assign conv_len   = `CONV_SCLK_PER_DIV * divider; // RULE14

    // Command capture, MSB first on rising serial clock
    assign nibble       = {shift_in[2:0], sdi_f};
    assign command      = {shift_in, sdi_f};
    assign nibble_done  = in_frame && sclk_rise && (bit_cnt == `NIBBLE_BITS - 5'd1);
    assign command_done = in_frame && sclk_rise && (bit_cnt == `FRAME_BITS - 5'd1);

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            in_frame <= 1'b0;
            bit_cnt  <= 5'd0;
            shift_in <= 15'h0000;
        end
        else if (frame_start)
        begin
            in_frame <= 1'b1;
            bit_cnt  <= 5'd0;
        end
        else if (frame_end)
            in_frame <= 1'b0;
        else if (in_frame && sclk_rise)
        begin
            shift_in <= command[14:0];
            if (bit_cnt == `FRAME_BITS - 5'd1)
                in_frame <= 1'b0;
            else
                bit_cnt <= bit_cnt + 5'd1;
        end
    end

    // Conversion admission per mode
    assign restricted    = threshold_hit && mode[1];
    assign convert_req   = nibble_done && (nibble == `CMD_CONVERT) && (state == ST_IDLE);
    assign restart_sweep = convert_req && (mode == `MODE_REPEAT_SWEEP) && threshold_hit; // RULE6 RULE7
    assign convert_ok    = convert_req &&
                           (((mode == `MODE_SINGLE) && channel_valid) ||          // RULE11
                            ((mode == `MODE_REPEAT) && channel_valid && !threshold_hit) || // RULE12
                            ((mode == `MODE_SWEEP) && !threshold_hit) ||          // RULE4 RULE5
                            (mode == `MODE_REPEAT_SWEEP));

    // Sampling window then conversion, both counted in serial clock periods
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            state     <= ST_IDLE;
            phase_cnt <= 8'd0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    phase_cnt <= 8'd0;
                    if (convert_ok)
                        state <= ST_SAMPLE;
                end
                ST_SAMPLE:
                    if (sclk_rise)
                    begin
                        if (phase_cnt == sample_len - 8'd1) // RULE3
                        begin
                            phase_cnt <= 8'd0;
                            state     <= ST_CONVERT;
                        end
                        else
                            phase_cnt <= phase_cnt + 8'd1;
                    end
                ST_CONVERT:
                    if (sclk_rise)
                    begin
                        if (phase_cnt == conv_len - 8'd1) // RULE14
                            state <= ST_IDLE;
                        else
                            phase_cnt <= phase_cnt + 8'd1;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    assign sample_hold       = (state == ST_SAMPLE);
    assign end_of_conversion = (state == ST_IDLE);
    assign conv_finish       = (state == ST_CONVERT) && sclk_rise && (phase_cnt == conv_len - 8'd1);
    assign conv_result       = above_positive_reference ? `CODE_ALL_ONES :   // RULE2
                               below_negative_reference ? `CODE_ALL_ZEROS :
                               raw_code;

    // Command execution at the end of a full frame
    assign cfg_write  = command_done && (nibble_done == 1'b0) && (command[15:12] == `CMD_WRITE_CONFIG);
    assign fifo_read  = command_done && (command[15:12] == `CMD_READ_FIFO);
    assign fifo_push  = conv_finish && (mode != `MODE_SINGLE); // RULE10
    assign fifo_clear = cfg_write || restart_sweep;             // RULE7 RULE11

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            configuration_register <= `CFG_RESET;
            sel_channel            <= 3'd0;
            channel_valid          <= 1'b0;
            out_word               <= 12'h000;
        end
        else
        begin
            if (conv_finish && (mode == `MODE_SINGLE))
                out_word <= conv_result; // RULE10
            if (command_done)
            begin
                case (command[15:12])
                    `CMD_WRITE_CONFIG:
                    begin
                        configuration_register <= command[11:0];
                        channel_valid          <= 1'b0; // RULE11
                    end
                    `CMD_READ_CONFIG:
                        out_word <= configuration_register;
                    `CMD_READ_FIFO:
                        out_word <= fifo_head;
                    `CMD_TEST_MID:
                        if (!restricted)
                            out_word <= `TEST_CODE_MID; // RULE1
                    `CMD_TEST_ZERO:
                        if (!restricted)
                            out_word <= `TEST_CODE_ZERO; // RULE1
                    `CMD_TEST_FULL:
                        if (!restricted)
                            out_word <= `TEST_CODE_FULL; // RULE1
                    `CMD_CONVERT, `CMD_POWER_DOWN:
                        out_word <= out_word;
                    default:
                        if (!restricted) // RULE5
                        begin
                            sel_channel   <= command[14:12];
                            channel_valid <= 1'b1;
                        end
                endcase
            end
        end
    end

    // Sweep position and threshold tracking
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            sweep_index   <= 3'd0;
            threshold_hit <= 1'b0;
        end
        else if (fifo_clear)
        begin
            sweep_index   <= 3'd0; // RULE6
            threshold_hit <= 1'b0;
        end
        else
        begin
            if (fifo_push && mode[1])
                sweep_index <= ({1'b0, sweep_index} == threshold - 4'd1) ? 3'd0 : sweep_index + 3'd1; // RULE13
            if (fifo_push && (fifo_count + 4'd1 == threshold))
                threshold_hit <= 1'b1; // RULE4
            else if (fifo_read && (fifo_count == 4'd1))
                threshold_hit <= 1'b0; // RULE8
        end
    end

    always @(posedge clk)
    begin
        if (!reset_n)
            analog_channel <= 3'd0;
        else if (convert_ok)
            analog_channel <= mode[1] ? (restart_sweep ? 3'd0 : sweep_index) : sel_channel;
    end

    adc_result_fifo u_fifo
    (
        .clk       (clk),
        .reset_n   (reset_n),
        .clear     (fifo_clear),
        .push      (fifo_push),
        .push_data (conv_result),
        .pop       (fifo_read),
        .head_data (fifo_head),
        .count     (fifo_count)
    );

    // Serial output: word loaded at frame start, shifted on falling serial clock
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            shift_out <= 16'h0000;
            sdo       <= 1'b0;
        end
        else if (frame_start)
        begin
            shift_out <= {out_word[10:0], 5'h00};
            sdo       <= out_word[11];
        end
        else if (in_frame && sclk_fall)
        begin
            sdo       <= shift_out[15];
            shift_out <= {shift_out[14:0], 1'b0};
        end
    end

    assign sdo_oe = !cs_n_f;

    // Sticky status; a new event wins over a clear in the same cycle
    assign events[`STAT_CONV_DONE] = conv_finish;
    assign events[`STAT_THRESHOLD] = fifo_push && (fifo_count + 4'd1 == threshold); // RULE15
    assign events[`STAT_IGNORED]   = convert_req && !convert_ok;

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            status     <= 3'b000;
            irq_enable <= 3'b000;
        end
        else
        begin
            if (wr && (addr == `REG_IRQ_CLEAR))
                status <= (status & ~wdata[`STAT_WIDTH-1:0]) | events;
            else
                status <= status | events;
            if (wr && (addr == `REG_IRQ_ENABLE))
                irq_enable <= wdata[`STAT_WIDTH-1:0];
        end
    end

    assign irq = |(status & irq_enable); // RULE15

    always @(posedge clk)
    begin
        if (!reset_n)
            rdata <= 32'h00000000;
        else if (rd)
        begin
            case (addr)
                `REG_STATUS:      rdata <= {29'h0, status};
                `REG_IRQ_ENABLE:  rdata <= {29'h0, irq_enable};
                `REG_CONFIG_VIEW: rdata <= {20'h0, configuration_register};
                `REG_FIFO_VIEW:   rdata <= {18'h00000, state, threshold_hit, channel_valid, sweep_index,
                                            sel_channel, fifo_count};
                default:          rdata <= 32'h00000000;
            endcase
        end
        else
            rdata <= 32'h00000000;
    end
endmodule // adc_conversion_mode_sequencer

// [tb/adc_seq_checker_assertions.sv]
// Port-level assertions of the conversion sequencer
`timescale 1ns/1ps
module adc_seq_checker
(
    input logic        clk,
    input logic        reset_n,
    input logic        sclk,
    input logic [2:0]  analog_channel,
    input logic        sample_hold,
    input logic        end_of_conversion,
    input logic [7:0]  addr,
    input logic [31:0] wdata,
    input logic        wr,
    input logic        rd,
    input logic [31:0] rdata,
    input logic        irq
);
    logic [11:0] hold_cnt;
    logic [11:0] low_cnt;
    logic [2:0]  en_q;
    logic        sclk_q;

    // Serial clock rises in the sampling window, cycles of the busy span, and a copy of the enables
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            hold_cnt <= 12'h000;
            low_cnt  <= 12'h000;
            en_q     <= 3'h0;
            sclk_q   <= 1'b0;
        end
        else
        begin
            sclk_q   <= sclk;
            hold_cnt <= sample_hold ? hold_cnt + {11'h000, sclk && !sclk_q} : 12'h000;
            low_cnt  <= !end_of_conversion ? low_cnt + 12'h001 : 12'h000;
            if (wr && addr == 8'h04)
                en_q <= wdata[2:0];
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_hold_marks_busy:
    assert property ($rose(sample_hold) |-> !end_of_conversion)
        else $error("sampling window opened while idle");
    a_sample_window:
    assert property ($fell(sample_hold) |-> hold_cnt == 12'h00c || hold_cnt == 12'h018)
        else $error("sampling window has the wrong length");
    a_conv_follows:
    assert property ($fell(sample_hold) |-> !end_of_conversion [*8])
        else $error("conversion did not follow sampling");
    a_conv_length:
    assert property ($rose(end_of_conversion) |-> low_cnt >= 12'h0ce)
        else $error("conversion ended too early");
    a_channel_steady:
    assert property (!end_of_conversion && !$past(end_of_conversion, 3) |-> $stable(analog_channel))
        else $error("channel changed during conversion");
    a_irq_masked:
    assert property ((wr && addr == 8'h04 && wdata[2:0] == 3'h0) ##1 !wr |=> !irq)
        else $error("interrupt high with all enables off");
    a_irq_from_status:
    assert property ((rd && addr == 8'h00) ##1 (|(rdata[2:0] & en_q)) |-> irq)
        else $error("enabled status bit without interrupt");
    a_fifo_depth:
    assert property (rd && addr == 8'h10 |=> rdata[3:0] <= 4'h8)
        else $error("fifo count above depth");
endmodule // adc_seq_checker

bind adc_conversion_mode_sequencer adc_seq_checker i_chk (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .analog_channel(analog_channel), .sample_hold(sample_hold), .end_of_conversion(end_of_conversion),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// [tb/host_serial_model.sv]
// Host serial port model: framed 16-bit commands and free conversion clocks
`timescale 1ns/1ps
module host_serial_model
(
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input  logic sdo,
    input  logic sdo_oe
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    // Output is taken just before each falling edge, as the device's pin synchronisers
    // delay sdo by more than a half period; it is only trusted while the device drives it
    task automatic frame(input logic [15:0] cmd, output logic [15:0] rx);
        cs_n = 1'b0;
        #203;
        for (int i = 15; i >= 0; i--)
        begin
            sdi = cmd[i];
            #40 sclk = 1'b1;
            #40 rx[i] = sdo_oe ? sdo : 1'bx;
            sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        sdi = ~sdi;
        #200;
    endtask

    // Conversion timing runs on serial clocks outside frames
    task automatic run(input int n);
        repeat (n)
        begin
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
    endtask
endmodule // host_serial_model

// [tb/tb_adc_conversion_mode_sequencer.sv]
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module tb_adc_conversion_mode_sequencer;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [11:0] raw_code = 12'h000;
    logic        above = 1'b0;
    logic        below = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    wire         cs_n, sclk, sdi, sdo, sdo_oe, sample_hold, eoc, irq;
    wire [2:0]   chan;
    wire [31:0]  rdata;
    logic [15:0] rx;
    logic [31:0] d;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          n_hold = 0;
    int          n_busy = 0;
    logic [3:0]  tcmd [3] = '{4'hb, 4'hc, 4'hd};
    logic [11:0] tcode [3] = '{12'h800, 12'h000, 12'hfff};

    always #5 clk = ~clk;

    adc_conversion_mode_sequencer i_dut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .analog_channel(chan), .sample_hold(sample_hold), .raw_code(raw_code),
        .above_positive_reference(above), .below_negative_reference(below), .end_of_conversion(eoc),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    host_serial_model i_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

    // Serial clock rises seen inside the sampling window and the busy span
    always @(posedge sclk)
    begin
        n_hold += sample_hold;
        n_busy += !eoc;
    end

    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic xfer(input logic [15:0] c);
        i_host.frame(c, rx);
    endtask

    task automatic conv(input logic [11:0] code);
        @(posedge clk) raw_code <= code;
        xfer(16'hf000);
        i_host.run(20);
    endtask

    task automatic fifo_count(input logic [3:0] exp);
        reg_rd(8'h10, d);
        check(d[3:0], exp);
    endtask

    initial
    begin
        #500000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_wr(8'h04, 32'h7);
        for (int k = 0; k < 3; k++)
        begin
            xfer({tcmd[k], 12'h000});
            xfer(16'h8000);
            check(rx, {tcode[k], 4'h0});
        end
        xfer(16'h3000);
        for (int j = 0; j < 3; j++)
        begin
            @(posedge clk);
            above <= (j == 1);
            below <= (j == 2);
            n_hold = 0;
            n_busy = 0;
            conv(12'h5a5);
            check(n_hold, 12);
            check(n_busy, 26);
            check(chan, 3'h3);
            xfer(16'h8000);
            check(rx[15:4], j == 1 ? 12'hfff : j == 2 ? 12'h000 : 12'h5a5);
        end
        @(posedge clk) below <= 1'b0;
        fifo_count(4'h0);
        xfer(16'ha000);
        reg_wr(8'h08, 32'h7);
        conv(12'h123);
        reg_rd(8'h00, d);
        check(d[2:0], 3'h4);
        xfer(16'ha04c);
        xfer(16'h5000);
        conv(12'h111);
        conv(12'h222);
        fifo_count(4'h2);
        check(irq, 1'b1);
        reg_rd(8'h00, d);
        check(d[1], 1'b1);
        conv(12'h333);
        fifo_count(4'h2);
        reg_wr(8'h04, 32'h0);
        check(irq, 1'b0);
        reg_wr(8'h04, 32'h7);
        reg_wr(8'h08, 32'h7);
        @(posedge clk);
        check(irq, 1'b0);
        xfer(16'he000);
        xfer(16'he000);
        check(rx[15:4], 12'h111);
        xfer(16'h8000);
        check(rx[15:4], 12'h222);
        conv(12'h444);
        check(chan, 3'h5);
        fifo_count(4'h1);
        xfer(16'ha08c);
        conv(12'h0aa);
        check(chan, 3'h0);
        conv(12'h0bb);
        check(chan, 3'h1);
        reg_wr(8'h08, 32'h7);
        conv(12'h0cc);
        fifo_count(4'h2);
        reg_rd(8'h00, d);
        check(d[2], 1'b1);
        xfer(16'he000);
        xfer(16'he000);
        check(rx[15:4], 12'h0aa);
        xfer(16'h8000);
        conv(12'h0dd);
        check(chan, 3'h0);
        xfer(16'ha0cc);
        reg_rd(8'h0c, d);
        check(d[11:0], 12'h0cc);
        conv(12'h001);
        conv(12'h002);
        conv(12'h003);
        fifo_count(4'h1);
        check(chan, 3'h0);
        xfer(16'ha0cc);
        fifo_count(4'h0);
        xfer(16'ha50c);
        xfer(16'h2000);
        n_hold = 0;
        n_busy = 0;
        conv(12'h777);
        i_host.run(24);
        check(n_hold, 24);
        check(n_busy, 52);
        xfer(16'h9000);
        check(rx[15:4], 12'h777);
        xfer(16'h8000);
        check(rx[15:4], 12'h50c);
        reg_rd(8'h20, d);
        check(d, 32'h0);
        finish_test();
    end
endmodule // tb_adc_conversion_mode_sequencer
